// ===== design/isx_exec.sv
`timescale 1ns/1ns
// How it works
// - Result is addressed file register plus one
// - Destination bit zero writes accumulator, not file register
// - Destination bit one writes file register
// - Skip variant tests result for zero
// - Zero result discards prefetched instruction, runs no-op
// - Skip variant one cycle, two when skipping
module isx_exec
  import isx_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              insn_valid_i,
  input  wire logic [INSN_W-1:0] insn_i,
  input  wire logic [DATA_W-1:0] file_rdata_i,
  output logic      [ADDR_W-1:0] file_addr_o,
  output logic                   file_we_o,
  output logic      [DATA_W-1:0] file_wdata_o,
  output logic                   acc_we_o,
  output logic      [DATA_W-1:0] acc_wdata_o,
  output logic                   zero_we_o,
  output logic                   zero_flag_o,
  output logic                   flush_o,
  output logic                   busy_o
);

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              is_inc;
  logic              is_skip;
  logic              dest_file;
  logic [DATA_W-1:0] sum;
  logic              sum_zero;
  logic              go;
  logic              skip_taken;

  isx_state_t        state;
  isx_state_t        next_state;
  logic              next_file_we;
  logic [DATA_W-1:0] next_file_wdata;
  logic              next_acc_we;
  logic [DATA_W-1:0] next_acc_wdata;
  logic              next_zero_we;
  logic              next_zero_flag;

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------

  always_comb begin
    is_inc    = insn_i[OPC_MSB:OPC_LSB] == OPC_INC;
    is_skip   = insn_i[OPC_MSB:OPC_LSB] == OPC_INC_SKIP;
    dest_file = insn_i[DEST_BIT];
  end

  // ----------------------------------------------------------------
  // Increment datapath
  // ----------------------------------------------------------------

  isx_incr u_incr (
    .value_i (file_rdata_i),
    .sum_o   (sum),
    .zero_o  (sum_zero)
  );

  // ----------------------------------------------------------------
  // Core handshake
  // ----------------------------------------------------------------

  always_comb begin
    file_addr_o = insn_i[ADDR_MSB:0];
    go          = insn_valid_i && (state == ISX_EXEC) && (is_inc || is_skip);
    skip_taken  = go && is_skip && sum_zero;
    flush_o     = skip_taken;
    busy_o      = (state == ISX_SKIP);
  end

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------

  always_comb begin
    next_state = state;
    case (state)
      ISX_EXEC: begin
        if (skip_taken) begin
          next_state = ISX_SKIP;
        end else if (go) begin
          next_state = ISX_EXEC;
        end else begin
          next_state = ISX_EXEC;
        end
      end
      ISX_SKIP: begin
        next_state = ISX_EXEC;
      end
      default: begin
        next_state = ISX_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ISX_EXEC;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // File register write
  // ----------------------------------------------------------------

  always_comb begin
    next_file_we    = 1'b0;
    next_file_wdata = file_wdata_o;
    case (state)
      ISX_EXEC: begin
        if (go && dest_file) begin
          next_file_we    = 1'b1;
          next_file_wdata = sum;
        end else if (go) begin
          next_file_we = 1'b0;
        end
      end
      ISX_SKIP: begin
        next_file_we    = 1'b0;
        next_file_wdata = file_wdata_o;
      end
      default: begin
        next_file_we    = 1'b0;
        next_file_wdata = file_wdata_o;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      file_we_o    <= 1'b0;
      file_wdata_o <= RESULT_RST;
    end else begin
      file_we_o    <= next_file_we;
      file_wdata_o <= next_file_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator write
  // ----------------------------------------------------------------

  always_comb begin
    next_acc_we    = 1'b0;
    next_acc_wdata = acc_wdata_o;
    case (state)
      ISX_EXEC: begin
        if (go && !dest_file) begin
          next_acc_we    = 1'b1;
          next_acc_wdata = sum;
        end else if (go) begin
          next_acc_we = 1'b0;
        end
      end
      ISX_SKIP: begin
        next_acc_we    = 1'b0;
        next_acc_wdata = acc_wdata_o;
      end
      default: begin
        next_acc_we    = 1'b0;
        next_acc_wdata = acc_wdata_o;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_we_o    <= 1'b0;
      acc_wdata_o <= RESULT_RST;
    end else begin
      acc_we_o    <= next_acc_we;
      acc_wdata_o <= next_acc_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Zero flag write
  // ----------------------------------------------------------------

  always_comb begin
    next_zero_we   = 1'b0;
    next_zero_flag = zero_flag_o;
    case (state)
      ISX_EXEC: begin
        if (go && is_inc) begin
          next_zero_we   = 1'b1;
          next_zero_flag = sum_zero;
        end else if (go && is_skip) begin
          next_zero_we = 1'b0;
        end
      end
      ISX_SKIP: begin
        next_zero_we   = 1'b0;
        next_zero_flag = zero_flag_o;
      end
      default: begin
        next_zero_we   = 1'b0;
        next_zero_flag = zero_flag_o;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zero_we_o   <= 1'b0;
      zero_flag_o <= ZERO_FLAG_RST;
    end else begin
      zero_we_o   <= next_zero_we;
      zero_flag_o <= next_zero_flag;
    end
  end

endmodule

// ===== common/isx_pkg.sv
package isx_pkg;

  // ----------------------------------------------------------------
  // Instruction word layout (14-bit)
  // ----------------------------------------------------------------
  localparam int unsigned INSN_W      = 14;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 7;
  localparam int unsigned OPC_MSB     = 13;
  localparam int unsigned OPC_LSB     = 8;
  localparam int unsigned DEST_BIT    = 7;
  localparam int unsigned ADDR_MSB    = 6;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0]  OPC_INC      = 6'h0_A;
  localparam logic [5:0]  OPC_INC_SKIP = 6'h0_F;

  // ----------------------------------------------------------------
  // Reset values and increment step
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h0_0;
  localparam logic [DATA_W-1:0] INC_STEP   = 8'h0_1;
  localparam logic              ZERO_FLAG_RST = 1'b0;

  typedef enum logic [1:0] {
    ISX_EXEC,
    ISX_SKIP
  } isx_state_t;

endpackage

// ===== design/isx_incr.sv
`timescale 1ns/1ns
module isx_incr
  import isx_pkg::*;
(
  input  wire logic [DATA_W-1:0] value_i,
  output logic      [DATA_W-1:0] sum_o,
  output logic                   zero_o
);

  // ----------------------------------------------------------------
  // Increment and zero test
  // ----------------------------------------------------------------
  always_comb begin
    sum_o  = value_i + INC_STEP;
    zero_o = (sum_o == RESULT_RST);
  end

endmodule

// ===== tb/isx_properties.sv
`timescale 1ns/1ns
module isx_chk
  import isx_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              insn_valid_i,
  input wire logic [INSN_W-1:0] insn_i,
  input wire logic [DATA_W-1:0] file_rdata_i,
  input wire logic [ADDR_W-1:0] file_addr_o,
  input wire logic              file_we_o,
  input wire logic [DATA_W-1:0] file_wdata_o,
  input wire logic              acc_we_o,
  input wire logic [DATA_W-1:0] acc_wdata_o,
  input wire logic              zero_we_o,
  input wire logic              zero_flag_o,
  input wire logic              flush_o,
  input wire logic              busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire [5:0] op  = insn_i[13:8];
  wire       tk  = insn_valid_i && !busy_o && (op == OPC_INC || op == OPC_INC_SKIP);
  wire [7:0] sum = file_rdata_i + INC_STEP;
  wire       zsk = tk && op == OPC_INC_SKIP && sum == 8'h0_0;
  sequence s_slot; busy_o ##1 !busy_o; endsequence
  sequence s_quiet; !file_we_o && !acc_we_o && !zero_we_o; endsequence
  property p_addr; file_addr_o == insn_i[ADDR_MSB:0]; endproperty
  property p_idle; !tk |=> s_quiet; endproperty
  property p_sum; tk |=> (file_we_o ? file_wdata_o : acc_wdata_o) == $past(sum); endproperty
  property p_acc; tk && !insn_i[7] |=> acc_we_o && !file_we_o; endproperty
  property p_file; tk && insn_i[7] |=> file_we_o && !acc_we_o; endproperty
  property p_flush; flush_o == zsk; endproperty
  property p_slot; zsk |=> s_slot; endproperty
  property p_zero; tk && op == OPC_INC |=> zero_we_o && zero_flag_o == ($past(sum) == 8'h0_0); endproperty
  property p_keep; tk && op == OPC_INC_SKIP |=> !zero_we_o; endproperty
  a_sum: assert property (p_sum) else $error("bad result");
  a_acc: assert property (p_acc) else $error("bad acc write");
  a_file: assert property (p_file) else $error("bad file write");
  a_flush: assert property (p_flush) else $error("bad flush");
  a_slot: assert property (p_slot) else $error("bad slot");
  a_zero: assert property (p_zero) else $error("bad zero flag");
  a_keep: assert property (p_keep) else $error("flag touched");
  a_addr: assert property (p_addr) else $error("bad address");
  a_idle: assert property (p_idle) else $error("write while idle");
endmodule
bind isx_exec isx_chk isx_chk_inst (
  .clock_i      (clock_i),
  .nrst_i       (nrst_i),
  .insn_valid_i (insn_valid_i),
  .insn_i       (insn_i),
  .file_rdata_i (file_rdata_i),
  .file_addr_o  (file_addr_o),
  .file_we_o    (file_we_o),
  .file_wdata_o (file_wdata_o),
  .acc_we_o     (acc_we_o),
  .acc_wdata_o  (acc_wdata_o),
  .zero_we_o    (zero_we_o),
  .zero_flag_o  (zero_flag_o),
  .flush_o      (flush_o),
  .busy_o       (busy_o)
);

// ===== tb/tb.sv
`timescale 1ns/1ns
module tb
  import isx_pkg::*;
;
  logic              clock_i = 0, nrst_i = 0, insn_valid_i = 0;
  logic [INSN_W-1:0] insn_i = '0;
  logic [DATA_W-1:0] file_rdata_i = '0, file_wdata_o, acc_wdata_o;
  logic [ADDR_W-1:0] file_addr_o;
  logic              file_we_o, acc_we_o, zero_we_o, zero_flag_o, flush_o, busy_o, bz = 0;
  int                n_mismatch = 0, tests_run = 0, cyc = 0;
  always #50 clock_i = ~clock_i;
  isx_exec isx_exec_inst (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .insn_valid_i (insn_valid_i),
    .insn_i       (insn_i),
    .file_rdata_i (file_rdata_i),
    .file_addr_o  (file_addr_o),
    .file_we_o    (file_we_o),
    .file_wdata_o (file_wdata_o),
    .acc_we_o     (acc_we_o),
    .acc_wdata_o  (acc_wdata_o),
    .zero_we_o    (zero_we_o),
    .zero_flag_o  (zero_flag_o),
    .flush_o      (flush_o),
    .busy_o       (busy_o)
  );
  function automatic logic [DATA_W-1:0] exp_sum(logic [DATA_W-1:0] f);
    return f + INC_STEP;
  endfunction
  function automatic logic taken(logic v, logic [INSN_W-1:0] w, logic b);
    return v && !b && (w[OPC_MSB:OPC_LSB] == OPC_INC || w[OPC_MSB:OPC_LSB] == OPC_INC_SKIP);
  endfunction
  task automatic chk(logic [DATA_W-1:0] got, logic [DATA_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic step(logic v, logic [INSN_W-1:0] w, logic [DATA_W-1:0] r);
    logic              tk;
    logic              sk;
    logic [DATA_W-1:0] s;
    insn_valid_i = v;
    insn_i       = w;
    file_rdata_i = r;
    #1;
    tk = taken(v, w, bz);
    sk = tk && w[OPC_MSB:OPC_LSB] == OPC_INC_SKIP;
    s  = exp_sum(r);
    chk(busy_o, bz);
    chk(flush_o, sk && s == 0);
    chk(file_addr_o, w[ADDR_MSB:0]);
    @(negedge clock_i);
    chk(file_we_o, tk && w[DEST_BIT]);
    chk(acc_we_o, tk && !w[DEST_BIT]);
    chk(zero_we_o, tk && !sk);
    if (tk) chk(w[DEST_BIT] ? file_wdata_o : acc_wdata_o, s);
    if (tk && !sk) chk(zero_flag_o, s == 0);
    bz = sk && s == 0;
  endtask
  always @(posedge clock_i) if (++cyc > 1000) begin
    n_mismatch++;
    test_done();
  end
  initial begin
    void'($urandom(55));
    repeat (2) @(negedge clock_i);
    nrst_i = 1;
    for (int i = 0; i < 400; i++) begin
      step($urandom_range(0, 3) != 0,
           {i % 5 == 0 ? 6'h3_C : (i[0] ? OPC_INC : OPC_INC_SKIP), 8'($urandom)},
           i % 3 == 0 ? 8'hF_F : 8'($urandom));
    end
    nrst_i       = 0;
    insn_valid_i = 0;
    #1;
    chk(busy_o, 1'b0);
    chk(file_we_o, 1'b0);
    chk(file_wdata_o, RESULT_RST);
    chk(acc_we_o, 1'b0);
    chk(acc_wdata_o, RESULT_RST);
    chk(zero_we_o, 1'b0);
    chk(zero_flag_o, 1'b0);
    bz = 0;
    repeat (2) @(negedge clock_i);
    nrst_i = 1;
    step(1'b1, {OPC_INC_SKIP, 8'h8_5}, 8'hF_F);
    step(1'b1, {OPC_INC, 8'h0_5}, 8'h4_1);
    step(1'b1, {OPC_INC, 8'h0_5}, 8'h4_1);
    step(1'b1, {OPC_INC, 8'h8_5}, 8'hF_F);
    step(1'b1, {OPC_INC_SKIP, 8'h0_5}, 8'h1_0);
    test_done();
  end
endmodule
